// *** src/ocdcu_defs.vh ***
// constants of the debugger command unit: offsets, fields, command codes
// assumes inclusion by ocdcu_top, ocdcu_gate and the testbench
`ifndef OCDCU_DEFS_VH
`define OCDCU_DEFS_VH

// apb register byte offsets
`define OCDCU_OFF_CTRL      12'h000
`define OCDCU_OFF_STAT      12'h004
`define OCDCU_OFF_REV       12'h008
`define OCDCU_OFF_CMD       12'h00c

// control register fields
`define OCDCU_CTRL_RESET    0
`define OCDCU_CTRL_LOOP     1
`define OCDCU_CTRL_DBG      7
`define OCDCU_CTRL_MASK     8'h83

// status register fields
`define OCDCU_STAT_IDLE     7
`define OCDCU_STAT_HALT     6
`define OCDCU_STAT_READ_PROTECT_FLAG     5

// debug command bytes
`define OCDCU_CMD_REV       8'h00
`define OCDCU_CMD_STAT      8'h02
`define OCDCU_CMD_WR_PC     8'h06
`define OCDCU_CMD_RD_PC     8'h07
`define OCDCU_CMD_WR_REG    8'h08
`define OCDCU_CMD_RD_REG    8'h09
`define OCDCU_CMD_WR_PMEM   8'h0a
`define OCDCU_CMD_RD_PMEM   8'h0b
`define OCDCU_CMD_WR_DMEM   8'h0c
`define OCDCU_CMD_RD_DMEM   8'h0d
`define OCDCU_CMD_CRC       8'h0e
`define OCDCU_CMD_RSVD0F    8'h0f
`define OCDCU_CMD_STEP      8'h10
`define OCDCU_CMD_STUFF     8'h11
`define OCDCU_CMD_EXEC      8'h12

// decode classes
`define OCDCU_CLS_REV       3'h0
`define OCDCU_CLS_STAT      3'h1
`define OCDCU_CLS_WRREG     3'h2
`define OCDCU_CLS_FWD       3'h3
`define OCDCU_CLS_DROP      3'h4

// reset values and parameter defaults
`define OCDCU_CTRL_RST      8'h00
`define OCDCU_REV_DEFAULT   16'h0100
`define OCDCU_FLASH_LO      12'hff8
`define OCDCU_FLASH_HI      12'hfff
`define OCDCU_FLASH_CTL     12'hff8
`define OCDCU_MASS_ERASE    8'h01

`endif

// *** src/ocdcu_gate.v ***
// command byte decoder with read-protect gating
// assumes a command byte and a stable read-protect level
`timescale 1ns/100ps
`include "ocdcu_defs.vh"

module ocdcu_gate
(
    input  wire [7:0] cmd,
    input  wire       rp_en,
    output reg  [2:0] cls,
    output reg        refused
);

    always @*
    begin
        cls     = `OCDCU_CLS_DROP;
        refused = 1'b0;
        case (cmd)
            `OCDCU_CMD_REV:    cls = `OCDCU_CLS_REV;
            `OCDCU_CMD_STAT:   cls = `OCDCU_CLS_STAT;
            `OCDCU_CMD_WR_REG: cls = `OCDCU_CLS_WRREG;
            `OCDCU_CMD_WR_PC, `OCDCU_CMD_RD_PC:
            begin
                cls     = rp_en ? `OCDCU_CLS_DROP : `OCDCU_CLS_FWD;
                refused = rp_en;
            end
            `OCDCU_CMD_RD_REG, `OCDCU_CMD_WR_PMEM, `OCDCU_CMD_RD_PMEM,
            `OCDCU_CMD_WR_DMEM, `OCDCU_CMD_RD_DMEM,
            `OCDCU_CMD_STEP, `OCDCU_CMD_STUFF, `OCDCU_CMD_EXEC:
            begin
                cls     = rp_en ? `OCDCU_CLS_DROP : `OCDCU_CLS_FWD;
                refused = rp_en;
            end
            `OCDCU_CMD_CRC:    cls = `OCDCU_CLS_FWD;
            default:           cls = `OCDCU_CLS_DROP;
        endcase
    end

endmodule

// *** src/ocdcu_top.v ***
// debugger command unit: command decode, answers, control and status
// assumes bytes from a debug pin deserialiser, apb master on pclk
//
// What this block does
// - refuse program counter commands under read protect
// - protected register writes: flash control, mass erase
// - protected: no register read, memory read/write
// - command byte first, then data, then answers
// - revision answer: major byte, then minor byte
// - status answer: one status register byte
// - break with loop bit 0 sets debug mode
// - break with loop bit 1 makes cpu loop
// - writing reset 1 resets device, not debugger
// - reset bit self-clears when reset finishes
// - status: idle 7, halt 6, protect 5
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "ocdcu_defs.vh"

module ocdcu_top
#(
    parameter [15:0] REVISION   = `OCDCU_REV_DEFAULT,
    parameter [11:0] FLASH_LO   = `OCDCU_FLASH_LO,
    parameter [11:0] FLASH_HI   = `OCDCU_FLASH_HI,
    parameter [11:0] FLASH_CTL  = `OCDCU_FLASH_CTL,
    parameter [7:0]  MASS_ERASE = `OCDCU_MASS_ERASE
)
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        host_byte_valid,
    input  wire        host_byte_first,
    input  wire [7:0]  host_byte,
    output reg         resp_valid,
    output reg  [7:0]  resp_byte,
    input  wire        resp_ready,
    output reg         cmd_go,
    output reg  [7:0]  cmd_code,
    output reg         cmd_refused,
    output reg         fwd_valid,
    output reg  [7:0]  fwd_byte,
    output reg         reg_wr_valid,
    output reg  [11:0] reg_wr_addr,
    output reg  [7:0]  reg_wr_data,
    input  wire        read_protect_flag,
    input  wire        halt_mode,
    input  wire        break_instruction,
    input  wire        sys_reset_done,
    output reg         debug_mode_flag,
    output reg         break_loop,
    output reg         sys_reset_req
);

    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_AHI   = 3'd1;
    localparam [2:0] ST_ALO   = 3'd2;
    localparam [2:0] ST_CNT   = 3'd3;
    localparam [2:0] ST_DATA  = 3'd4;
    localparam [2:0] ST_FWD   = 3'd5;
    localparam [2:0] ST_DROP  = 3'd6;
    localparam [2:0] ST_MINOR = 3'd7;

    reg  [2:0]  state;
    reg  [11:0] wr_addr;
    reg  [7:0]  wr_left;
    reg         brk_seen;
    reg         last_refused;
    wire [2:0]  gate_cls;
    wire        gate_refused;
    wire        setup;
    wire        acc_wr;
    wire        ctrl_wr;
    wire        byte_cmd;
    wire        byte_dat;
    wire        resp_busy;
    wire        wr_ok;
    wire [7:0]  ctrl_val;
    wire [7:0]  stat_val;

    function addr_mapped;
        input [11:0] a;
        begin
            addr_mapped = (a == `OCDCU_OFF_CTRL) || (a == `OCDCU_OFF_STAT) ||
                          (a == `OCDCU_OFF_REV)  || (a == `OCDCU_OFF_CMD);
        end
    endfunction

    ocdcu_gate u_gate
    (
        .cmd     (host_byte),
        .rp_en   (read_protect_flag),
        .cls     (gate_cls),
        .refused (gate_refused)
    );

    assign setup     = psel & ~penable;
    assign acc_wr    = psel & penable & pready & pwrite & ~pslverr;
    assign ctrl_wr   = acc_wr & (paddr == `OCDCU_OFF_CTRL);
    assign byte_cmd  = host_byte_valid & host_byte_first;
    assign byte_dat  = host_byte_valid & ~host_byte_first;
    assign resp_busy = resp_valid & ~resp_ready;

    // flash control window check under read protection
    assign wr_ok = ~read_protect_flag ||
                   ((wr_addr >= FLASH_LO) && (wr_addr <= FLASH_HI) &&
                    ((wr_addr != FLASH_CTL) || (host_byte == MASS_ERASE)));

    assign ctrl_val = {debug_mode_flag, 5'h00, break_loop, sys_reset_req};
    assign stat_val = {debug_mode_flag | brk_seen, halt_mode, read_protect_flag, 5'h00};

    // apb slave, zero wait states
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & ~addr_mapped(paddr);
            if (setup)
            begin
                case (paddr)
                    `OCDCU_OFF_CTRL: prdata <= {24'h000000, ctrl_val};
                    `OCDCU_OFF_STAT: prdata <= {24'h000000, stat_val};
                    `OCDCU_OFF_REV:  prdata <= {16'h0000, REVISION};
                    `OCDCU_OFF_CMD:  prdata <= {23'h000000, last_refused, cmd_code};
                    default:         prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // control bits, break handling and commanded reset
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            debug_mode_flag <= 1'b0;
            break_loop      <= 1'b0;
            sys_reset_req   <= 1'b0;
            brk_seen        <= 1'b0;
        end
        else
        begin
            if (ctrl_wr)
            begin
                break_loop <= pwdata[`OCDCU_CTRL_LOOP];
            end
            if (break_instruction & ~break_loop)
            begin
                debug_mode_flag <= 1'b1;
            end
            else if (ctrl_wr)
            begin
                debug_mode_flag <= pwdata[`OCDCU_CTRL_DBG];
            end
            if (break_instruction)
            begin
                brk_seen <= 1'b1;
            end
            else if (ctrl_wr)
            begin
                brk_seen <= 1'b0;
            end
            if (ctrl_wr & pwdata[`OCDCU_CTRL_RESET])
            begin
                sys_reset_req <= 1'b1;
            end
            else if (sys_reset_done)
            begin
                sys_reset_req <= 1'b0;
            end
        end
    end

    // command and data byte sequencer
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state        <= ST_IDLE;
            wr_addr      <= 12'h000;
            wr_left      <= 8'h00;
            resp_valid   <= 1'b0;
            resp_byte    <= 8'h00;
            cmd_go       <= 1'b0;
            cmd_code     <= 8'h00;
            cmd_refused  <= 1'b0;
            last_refused <= 1'b0;
            fwd_valid    <= 1'b0;
            fwd_byte     <= 8'h00;
            reg_wr_valid <= 1'b0;
            reg_wr_addr  <= 12'h000;
            reg_wr_data  <= 8'h00;
        end
        else
        begin
            cmd_go       <= 1'b0;
            cmd_refused  <= 1'b0;
            fwd_valid    <= 1'b0;
            reg_wr_valid <= 1'b0;
            if (resp_valid & resp_ready)
            begin
                resp_valid <= 1'b0;
            end
            if (byte_cmd & ~resp_busy)
            begin
                cmd_code     <= host_byte;
                last_refused <= gate_refused;
                cmd_refused  <= gate_refused;
                case (gate_cls)
                    `OCDCU_CLS_REV:
                    begin
                        resp_valid <= 1'b1;
                        resp_byte  <= REVISION[15:8];
                        state      <= ST_MINOR;
                    end
                    `OCDCU_CLS_STAT:
                    begin
                        resp_valid <= 1'b1;
                        resp_byte  <= stat_val;
                        state      <= ST_IDLE;
                    end
                    `OCDCU_CLS_WRREG:
                    begin
                        cmd_go <= 1'b1;
                        state  <= ST_AHI;
                    end
                    `OCDCU_CLS_FWD:
                    begin
                        cmd_go <= 1'b1;
                        state  <= ST_FWD;
                    end
                    default:
                    begin
                        state <= ST_DROP;
                    end
                endcase
            end
            else
            begin
                case (state)
                    ST_MINOR:
                    begin
                        if (~resp_busy)
                        begin
                            resp_valid <= 1'b1;
                            resp_byte  <= REVISION[7:0];
                            state      <= ST_IDLE;
                        end
                    end
                    ST_AHI:
                    begin
                        if (byte_dat)
                        begin
                            wr_addr[11:8] <= host_byte[3:0];
                            state         <= ST_ALO;
                        end
                    end
                    ST_ALO:
                    begin
                        if (byte_dat)
                        begin
                            wr_addr[7:0] <= host_byte;
                            state        <= ST_CNT;
                        end
                    end
                    ST_CNT:
                    begin
                        if (byte_dat)
                        begin
                            wr_left <= host_byte;
                            state   <= (host_byte == 8'h00) ? ST_IDLE : ST_DATA;
                        end
                    end
                    ST_DATA:
                    begin
                        if (byte_dat)
                        begin
                            reg_wr_valid <= wr_ok;
                            cmd_refused  <= ~wr_ok;
                            if (~wr_ok)
                            begin
                                last_refused <= 1'b1;
                            end
                            reg_wr_addr  <= wr_addr;
                            reg_wr_data  <= host_byte;
                            wr_addr      <= wr_addr + 12'h001;
                            wr_left      <= wr_left - 8'h01;
                            if (wr_left == 8'h01)
                            begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_FWD:
                    begin
                        if (byte_dat)
                        begin
                            fwd_valid <= 1'b1;
                            fwd_byte  <= host_byte;
                        end
                    end
                    ST_DROP:
                    begin
                        state <= ST_DROP;
                    end
                    default:
                    begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// *** testbench/ocdcu_properties.sv ***
// port assertions for the debugger command unit
// assumes a bind onto ocdcu_top, one clock pclk
`timescale 1ns/100ps
module ocdcu_props
#(
    parameter [15:0] REVISION   = 16'h0100,
    parameter [11:0] FLASH_LO   = 12'hff8,
    parameter [11:0] FLASH_HI   = 12'hfff,
    parameter [11:0] FLASH_CTL  = 12'hff8,
    parameter [7:0]  MASS_ERASE = 8'h01
)
(
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        host_byte_valid,
    input wire        host_byte_first,
    input wire [7:0]  host_byte,
    input wire        resp_valid,
    input wire [7:0]  resp_byte,
    input wire        cmd_go,
    input wire        cmd_refused,
    input wire        reg_wr_valid,
    input wire [11:0] reg_wr_addr,
    input wire [7:0]  reg_wr_data,
    input wire        read_protect_flag,
    input wire        halt_mode,
    input wire        break_instruction,
    input wire        sys_reset_done,
    input wire        debug_mode_flag,
    input wire        break_loop,
    input wire        sys_reset_req
);
    wire cmd = host_byte_valid && host_byte_first && !resp_valid;
    wire ctl_wr = psel && penable && pwrite && paddr == 12'h000;
    wire rsvd = host_byte == 8'h01 || (host_byte > 8'h02 && host_byte < 8'h06) || host_byte == 8'h0f
        || host_byte > 8'h12;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_rev_major: assert property (cmd && host_byte == 8'h00 |=> resp_valid && resp_byte == REVISION[15:8])
        else $error("revision answer wrong");
    a_stat_byte: assert property (cmd && host_byte == 8'h02 |=> resp_valid
        && resp_byte[6:0] == {$past(halt_mode), $past(read_protect_flag), 5'h00}) else $error("status answer wrong");
    a_pc_refused: assert property (cmd && read_protect_flag && host_byte[7:1] == 7'h03
        |=> cmd_refused && !cmd_go) else $error("pc command not refused");
    a_prot_refused: assert property (cmd && read_protect_flag && host_byte > 8'h08
        && host_byte < 8'h0e |=> cmd_refused && !cmd_go) else $error("protected command not refused");
    a_rsvd_quiet: assert property (cmd && rsvd |=> (!resp_valid && !cmd_go && !cmd_refused)[*2])
        else $error("reserved command acted on");
    a_flash_only: assert property (reg_wr_valid && read_protect_flag |-> reg_wr_addr >= FLASH_LO
        && reg_wr_addr <= FLASH_HI && (reg_wr_addr != FLASH_CTL || reg_wr_data == MASS_ERASE))
        else $error("protected register write let through");
    a_break_debug: assert property (break_instruction && !break_loop |=> debug_mode_flag)
        else $error("break did not enter debug mode");
    a_break_loops: assert property (break_instruction && break_loop && !debug_mode_flag && !ctl_wr
        |=> !debug_mode_flag) else $error("looping break entered debug mode");
    a_reset_req: assert property (ctl_wr && pwdata[0] |=> sys_reset_req)
        else $error("reset request not raised");
    a_reset_clear: assert property (sys_reset_done && sys_reset_req && !ctl_wr |=> !sys_reset_req)
        else $error("reset request not cleared");
endmodule

bind ocdcu_top ocdcu_props #(.REVISION(REVISION), .FLASH_LO(FLASH_LO), .FLASH_HI(FLASH_HI),
    .FLASH_CTL(FLASH_CTL), .MASS_ERASE(MASS_ERASE)) i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .host_byte_valid(host_byte_valid),
    .host_byte_first(host_byte_first), .host_byte(host_byte), .resp_valid(resp_valid), .resp_byte(resp_byte),
    .cmd_go(cmd_go), .cmd_refused(cmd_refused), .reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .read_protect_flag(read_protect_flag), .halt_mode(halt_mode),
    .break_instruction(break_instruction), .sys_reset_done(sys_reset_done), .debug_mode_flag(debug_mode_flag),
    .break_loop(break_loop), .sys_reset_req(sys_reset_req));

// *** testbench/ocdcu_host.sv ***
// debug host model: sends command and data bytes, takes answers
// assumes put and take are called from one bench process
`timescale 1ns/100ps
module ocdcu_host
(
    input  wire       pclk,
    input  wire       resp_valid,
    input  wire [7:0] resp_byte,
    output reg        host_byte_valid,
    output reg        host_byte_first,
    output reg  [7:0] host_byte,
    output reg        resp_ready
);
    integer stall = 0;
    initial
    begin
        host_byte_valid = 1'b0;
        host_byte_first = 1'b0;
        host_byte = 8'h00;
        resp_ready = 1'b0;
    end
    task put(input [7:0] b, input f);
    begin
        @(posedge pclk);
        host_byte_valid <= 1'b1;
        host_byte_first <= f;
        host_byte <= b;
        @(posedge pclk);
        host_byte_valid <= 1'b0;
        host_byte <= ~b;
    end
    endtask
    // slow host holds off ready for stall cycles
    task take(output [7:0] b, output ok);
        integer n;
    begin
        ok = 1'b0;
        repeat (stall) @(posedge pclk);
        resp_ready <= 1'b1;
        for (n = 0; n < 20 && !ok; n = n + 1)
        begin
            @(posedge pclk);
            ok = resp_valid;
            b = resp_byte;
        end
        resp_ready <= 1'b0;
    end
    endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the debugger command unit
// assumes host model ocdcu_host and the bound checker
`timescale 1ns/100ps
`include "ocdcu_defs.vh"
module testbench;
    localparam [15:0] REV = 16'h0305;
    reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h00000000;
    reg         read_protect_flag = 1'b0, halt_mode = 1'b0, break_instruction = 1'b0, sys_reset_done = 1'b0;
    wire [31:0] prdata;
    wire [11:0] wr_addr;
    wire [7:0]  host_byte, resp_byte, wr_data;
    wire        pready, pslverr, host_byte_valid, host_byte_first, resp_valid, resp_ready, cmd_go, cmd_refused;
    wire        wr_valid, debug_mode_flag, break_loop, sys_reset_req;
    integer     error_cnt = 0, checks_done = 0, cyc = 0, n_go = 0, n_ref = 0, n_wr = 0, w0, f0;
    integer     n_fwd = 0, fw0;
    wire        fwd_v;
    wire [7:0]  fwd_b;
    reg  [7:0]  last_fwd = 8'h00;
    reg  [19:0] last_wr = 20'h00000;
    reg  [31:0] r;
    reg         e;
    ocdcu_top #(.REVISION(REV)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_byte_valid(host_byte_valid), .host_byte_first(host_byte_first), .host_byte(host_byte),
        .resp_valid(resp_valid), .resp_byte(resp_byte), .resp_ready(resp_ready), .cmd_go(cmd_go), .cmd_code(),
        .cmd_refused(cmd_refused), .fwd_valid(fwd_v), .fwd_byte(fwd_b), .reg_wr_valid(wr_valid),
        .reg_wr_addr(wr_addr),
        .reg_wr_data(wr_data), .read_protect_flag(read_protect_flag), .halt_mode(halt_mode),
        .break_instruction(break_instruction), .sys_reset_done(sys_reset_done),
        .debug_mode_flag(debug_mode_flag), .break_loop(break_loop), .sys_reset_req(sys_reset_req));
    ocdcu_host i_host (.pclk(pclk), .resp_valid(resp_valid), .resp_byte(resp_byte),
        .host_byte_valid(host_byte_valid), .host_byte_first(host_byte_first), .host_byte(host_byte),
        .resp_ready(resp_ready));
    initial
    begin
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        n_go <= n_go + cmd_go;
        n_ref <= n_ref + cmd_refused;
        n_wr <= n_wr + wr_valid;
        n_fwd <= n_fwd + fwd_v;
        if (fwd_v)
            last_fwd <= fwd_b;
        if (wr_valid)
            last_wr <= {wr_addr, wr_data};
        if (cyc == 5000)
        begin
            error_cnt = error_cnt + 1;
            stop_test;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    end
    endtask
    task acc(input w, input [11:0] a, input [31:0] d, input [31:0] x, input xe);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, e}, {31'h0, xe});
        if (!w)
            chk(r, x);
    end
    endtask
    task get(input [7:0] x);
        reg [7:0] b;
        reg       ok;
    begin
        i_host.take(b, ok);
        chk({23'h0, ok, b}, {23'h0, 1'b1, x});
    end
    endtask
    // command byte first, then its data bytes
    task frame(input [55:0] s, input integer nb);
        integer k;
    begin
        for (k = 0; k < nb; k = k + 1)
            i_host.put(s[55 - 8 * k -: 8], k == 0);
        repeat (3) @(posedge pclk);
    end
    endtask
    task sweep(input p, input [31:0] xg, input [31:0] xr);
        integer g, f, k;
    begin
        read_protect_flag <= p;
        g = n_go;
        f = n_ref;
        for (k = 1; k < 20; k = k + 1)
            if (k != 2)
                i_host.put(k[7:0], 1'b1);
        frame({8'hff, 48'h0}, 1);
        chk(n_go - g, xg);
        chk(n_ref - f, xr);
    end
    endtask
    task stop_test;
    begin
        $display("checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        acc(0, `OCDCU_OFF_CTRL, 0, 32'h0, 0);
        acc(0, `OCDCU_OFF_REV, 0, {16'h0, REV}, 0);
        acc(0, 12'h010, 0, 32'h0, 1);
        halt_mode <= 1'b1;
        frame({8'h02, 48'h0}, 1);
        get(8'h40);
        i_host.stall = 3;
        frame({8'h00, 48'h0}, 1);
        get(REV[15:8]);
        get(REV[7:0]);
        i_host.stall = 0;
        $display("test answers done");
        sweep(0, 12, 0);
        sweep(1, 2, 10);
        $display("test protect gating done");
        w0 = n_wr;
        f0 = n_ref;
        frame({8'h08, 8'h0f, 8'hf8, 8'h03, 8'h01, 8'h02, 8'h05}, 7);
        chk(last_wr, {12'hffa, 8'h05});
        frame({8'h08, 8'h0f, 8'hf8, 8'h01, 8'h07, 16'h0}, 5);
        frame({8'h08, 8'h00, 8'h10, 8'h01, 8'h33, 16'h0}, 5);
        chk(n_wr - w0, 3);
        chk(n_ref - f0, 2);
        acc(0, `OCDCU_OFF_CMD, 0, 32'h108, 0);
        fw0 = n_fwd;
        frame({8'h06, 8'h3c, 40'h0}, 2);
        read_protect_flag <= 1'b0;
        frame({8'h0e, 8'ha5, 40'h0}, 2);
        chk(n_fwd - fw0, 1);
        chk({24'h0, last_fwd}, 32'ha5);
        read_protect_flag <= 1'b1;
        $display("test protected writes done");
        acc(1, `OCDCU_OFF_CTRL, 32'h02, 0, 0);
        break_instruction <= 1'b1;
        @(posedge pclk);
        break_instruction <= 1'b0;
        acc(0, `OCDCU_OFF_STAT, 0, 32'he0, 0);
        acc(1, `OCDCU_OFF_CTRL, 32'h00, 0, 0);
        acc(0, `OCDCU_OFF_STAT, 0, 32'h60, 0);
        break_instruction <= 1'b1;
        @(posedge pclk);
        break_instruction <= 1'b0;
        acc(0, `OCDCU_OFF_CTRL, 0, 32'h80, 0);
        acc(1, `OCDCU_OFF_CTRL, 32'h81, 0, 0);
        acc(1, `OCDCU_OFF_CTRL, 32'h80, 0, 0);
        acc(0, `OCDCU_OFF_CTRL, 0, 32'h81, 0);
        sys_reset_done <= 1'b1;
        @(posedge pclk);
        sys_reset_done <= 1'b0;
        acc(0, `OCDCU_OFF_CTRL, 0, 32'h80, 0);
        $display("test control done");
        stop_test;
    end
endmodule
